// [rtl/uhpd_pkg.sv]
// Package with register map, field layout, reset values and timing of the periodic/hub block.
package uhpd_pkg;

  // ==========================================================================
  // Register map (word indices on the plain register port)
  // ==========================================================================
  localparam logic [3:0] UHPD_ADDR_PERIODIC  = 4'h0;
  localparam logic [3:0] UHPD_ADDR_LOWSPEED  = 4'h1;
  localparam logic [3:0] UHPD_ADDR_HUBDESC   = 4'h2;
  localparam logic [3:0] UHPD_ADDR_INTERVAL  = 4'h3;
  localparam logic [3:0] UHPD_ADDR_STATUS    = 4'h4;
  localparam logic [3:0] UHPD_ADDR_TIMELEFT  = 4'h5;

  // ==========================================================================
  // Field positions and widths
  // ==========================================================================
  localparam int UHPD_PRD_W        = 16;
  localparam int UHPD_PRD_USED_W   = 14;
  localparam int UHPD_LS_W         = 12;
  localparam int UHPD_FI_W         = 14;
  localparam int UHPD_PGOOD_LSB    = 24;
  localparam int UHPD_PGOOD_W      = 8;
  localparam int UHPD_NO_OC_BIT    = 12;
  localparam int UHPD_OC_MODE_BIT  = 11;
  localparam int UHPD_COMPOUND_BIT = 10;
  localparam int UHPD_NO_SW_BIT    = 9;
  localparam int UHPD_SW_MODE_BIT  = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] UHPD_PRD_RST    = 16'h0000;
  localparam logic [11:0] UHPD_LS_RST     = 12'h628;
  localparam logic [13:0] UHPD_FI_RST     = 14'h2EDF;
  localparam logic [7:0]  UHPD_PGOOD_RST  = 8'h01;
  localparam logic        UHPD_NO_OC_RST  = 1'b0;
  localparam logic        UHPD_NO_SW_RST  = 1'b0;
  localparam logic        UHPD_SWMODE_RST = 1'b1;

  // ==========================================================================
  // Timing: one full-speed bit time is 1/12 MHz; the clock is 10 MHz.
  // ==========================================================================
  localparam int UHPD_CLK_HZ       = 10_000_000;
  localparam int UHPD_BIT_HZ       = 12_000_000;

  typedef enum logic [1:0] {
    UHPD_SCH_IDLE,
    UHPD_SCH_ASYNC,
    UHPD_SCH_PERIODIC
  } uhpd_sched_t;

endpackage

// [rtl/uhpd_bit_tick.sv]
// Bit-time tick generator: phase accumulator producing full-speed bit time strobes.
`timescale 1ns/1ps
module uhpd_bit_tick
  import uhpd_pkg::*;
#(
  parameter int CLK_HZ = UHPD_CLK_HZ,
  parameter int BIT_HZ = UHPD_BIT_HZ
)
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic clk_en,
  output logic      tick
);

  // ==========================================================================
  // Accumulator
  // ==========================================================================
  // The bit rate may exceed the clock, so a tick marks that at least one bit
  // time elapsed; the accumulator saturates, so bits beyond one per clock are dropped.
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic        tick_nxt;

  if (CLK_HZ <= 0 || BIT_HZ <= 0)
  begin : g_bad_rate
    $error("uhpd_bit_tick: rates must be positive");
  end

  always_comb
  begin
    acc_nxt  = acc_r + 32'(BIT_HZ);
    tick_nxt = 1'b0;
    if (acc_nxt >= 32'(CLK_HZ))
    begin
      acc_nxt  = acc_nxt - 32'(CLK_HZ);
      tick_nxt = 1'b1;
    end
    if (acc_nxt >= 32'(CLK_HZ))
    begin
      acc_nxt = 32'(CLK_HZ) - 32'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      acc_r <= 32'h0;
      tick  <= 1'b0;
    end
    else if (clk_en)
    begin
      acc_r <= acc_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule

// [rtl/uhpd_core.sv]
// Periodic priority, low-speed gate and first root hub descriptor of the USB host engine.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module uhpd_core
  import uhpd_pkg::*;
#(
  parameter int FI_W = UHPD_FI_W
)
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        async_req,
  input  wire logic        async_done,
  input  wire logic        periodic_req,
  input  wire logic        periodic_done,
  input  wire logic        ls_req,
  output logic             async_grant,
  output logic             periodic_grant,
  output logic             ls_start_ok,
  output logic             periodic_priority,
  output logic             frame_boundary,
  output logic [FI_W-1:0]  frame_time_left,
  output logic             ports_power_ganged,
  output logic             overcurrent_per_port,
  output logic             overcurrent_enabled
);

  // The timer mirrors a fixed fourteen-bit register, so other widths are refused.
  if (FI_W != UHPD_FI_W)
  begin : g_bad_width
    $error("uhpd_core: frame counter width must be fourteen bits");
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [UHPD_PRD_W-1:0]    periodic_threshold_value_r, periodic_threshold_value_nxt;
  logic [UHPD_LS_W-1:0]     low_speed_threshold_value_r, low_speed_threshold_value_nxt;
  logic [UHPD_PGOOD_W-1:0]  power_good_wait_time_r, power_good_wait_time_nxt;
  logic                     no_overcurrent_protection_r, no_overcurrent_protection_nxt;
  logic                     overcurrent_report_mode_r, overcurrent_report_mode_nxt;
  logic                     no_power_switching_r, no_power_switching_nxt;
  logic                     power_switching_mode_r, power_switching_mode_nxt;
  logic [FI_W-1:0]          frame_interval_r, frame_interval_nxt;
  logic [31:0]              rdata_nxt;
  logic [31:0]              hubdesc_word;

  assign hubdesc_word = {power_good_wait_time_r, 11'h000, no_overcurrent_protection_r,
                         overcurrent_report_mode_r, 1'b0, no_power_switching_r,
                         power_switching_mode_r, 8'h00};

  always_comb
  begin
    periodic_threshold_value_nxt  = periodic_threshold_value_r;
    low_speed_threshold_value_nxt = low_speed_threshold_value_r;
    power_good_wait_time_nxt      = power_good_wait_time_r;
    no_overcurrent_protection_nxt = no_overcurrent_protection_r;
    overcurrent_report_mode_nxt   = overcurrent_report_mode_r;
    no_power_switching_nxt        = no_power_switching_r;
    power_switching_mode_nxt      = power_switching_mode_r;
    frame_interval_nxt            = frame_interval_r;
    rdata_nxt                     = 32'h0;
    if (reg_wr)
    begin
      case (reg_addr)
        UHPD_ADDR_PERIODIC: periodic_threshold_value_nxt = reg_wdata[UHPD_PRD_W-1:0];
        UHPD_ADDR_LOWSPEED: low_speed_threshold_value_nxt = reg_wdata[UHPD_LS_W-1:0];
        UHPD_ADDR_HUBDESC:
        begin
          power_good_wait_time_nxt      = reg_wdata[UHPD_PGOOD_LSB +: UHPD_PGOOD_W];
          no_overcurrent_protection_nxt = reg_wdata[UHPD_NO_OC_BIT];
          overcurrent_report_mode_nxt   = reg_wdata[UHPD_OC_MODE_BIT];
          no_power_switching_nxt        = reg_wdata[UHPD_NO_SW_BIT];
          power_switching_mode_nxt      = reg_wdata[UHPD_SW_MODE_BIT];
        end
        UHPD_ADDR_INTERVAL: frame_interval_nxt = reg_wdata[FI_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        UHPD_ADDR_PERIODIC: rdata_nxt = {16'h0000, periodic_threshold_value_r};
        UHPD_ADDR_LOWSPEED: rdata_nxt = {20'h00000, low_speed_threshold_value_r};
        UHPD_ADDR_HUBDESC:  rdata_nxt = hubdesc_word;
        UHPD_ADDR_INTERVAL: rdata_nxt = {18'h00000, frame_interval_r};
        UHPD_ADDR_STATUS:   rdata_nxt = {29'h0, ls_start_ok, periodic_grant,
                                         periodic_priority};
        UHPD_ADDR_TIMELEFT: rdata_nxt = {18'h00000, frame_time_left};
        default:            rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      periodic_threshold_value_r  <= UHPD_PRD_RST;
      low_speed_threshold_value_r <= UHPD_LS_RST;
      power_good_wait_time_r      <= UHPD_PGOOD_RST;
      no_overcurrent_protection_r <= UHPD_NO_OC_RST;
      overcurrent_report_mode_r   <= UHPD_SWMODE_RST;
      no_power_switching_r        <= UHPD_NO_SW_RST;
      power_switching_mode_r      <= UHPD_SWMODE_RST;
      frame_interval_r            <= UHPD_FI_RST;
      reg_rdata                   <= 32'h0;
    end
    else if (clk_en)
    begin
      periodic_threshold_value_r  <= periodic_threshold_value_nxt;
      low_speed_threshold_value_r <= low_speed_threshold_value_nxt;
      power_good_wait_time_r      <= power_good_wait_time_nxt;
      no_overcurrent_protection_r <= no_overcurrent_protection_nxt;
      overcurrent_report_mode_r   <= overcurrent_report_mode_nxt;
      no_power_switching_r        <= no_power_switching_nxt;
      power_switching_mode_r      <= power_switching_mode_nxt;
      frame_interval_r            <= frame_interval_nxt;
      reg_rdata                   <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Frame timer and scheduler
  // ==========================================================================
  logic            bit_tick;
  logic [FI_W-1:0] time_left_nxt;
  logic            boundary_nxt;
  logic            prio_nxt;
  uhpd_sched_t     sched_r, sched_nxt;
  logic            ls_ok_nxt;
  logic            ganged_nxt, oc_pp_nxt, oc_en_nxt;

  uhpd_bit_tick u_bit_tick (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clk_en  (clk_en),
    .tick    (bit_tick)
  );

  always_comb
  begin
    time_left_nxt = frame_time_left;
    boundary_nxt  = 1'b0;
    prio_nxt      = periodic_priority;
    if (bit_tick)
    begin
      if (frame_time_left == '0)
      begin
        time_left_nxt = frame_interval_r;
        boundary_nxt  = 1'b1;
        prio_nxt      = 1'b0;
      end
      else
      begin
        time_left_nxt = frame_time_left - 1'b1;
      end
    end
    // Equality alone would miss a threshold written after the match, so
    // the flag also latches once the count has passed below it.
    if (!boundary_nxt && periodic_threshold_value_r[UHPD_PRD_USED_W-1:0] != '0 &&
        frame_time_left <= periodic_threshold_value_r[UHPD_PRD_USED_W-1:0])
    begin
      prio_nxt = 1'b1;
    end
    sched_nxt = sched_r;
    case (sched_r)
      UHPD_SCH_IDLE:
      begin
        if (periodic_req && (prio_nxt || !async_req))
        begin
          sched_nxt = UHPD_SCH_PERIODIC;
        end
        else if (async_req && !prio_nxt)
        begin
          sched_nxt = UHPD_SCH_ASYNC;
        end
      end
      UHPD_SCH_ASYNC:
      begin
        if (async_done)
        begin
          sched_nxt = UHPD_SCH_IDLE;
        end
      end
      UHPD_SCH_PERIODIC:
      begin
        if (periodic_done)
        begin
          sched_nxt = UHPD_SCH_IDLE;
        end
      end
      default: sched_nxt = UHPD_SCH_IDLE;
    endcase
    ls_ok_nxt = ls_req && (time_left_nxt >= FI_W'(low_speed_threshold_value_r));
    ganged_nxt = !no_power_switching_r && !power_switching_mode_r;
    oc_en_nxt  = !no_overcurrent_protection_r;
    oc_pp_nxt  = !no_overcurrent_protection_r && overcurrent_report_mode_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      frame_time_left      <= '0;
      frame_boundary       <= 1'b0;
      periodic_priority    <= 1'b0;
      sched_r              <= UHPD_SCH_IDLE;
      async_grant          <= 1'b0;
      periodic_grant       <= 1'b0;
      ls_start_ok          <= 1'b0;
      ports_power_ganged   <= 1'b0;
      overcurrent_per_port <= 1'b0;
      overcurrent_enabled  <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_time_left      <= time_left_nxt;
      frame_boundary       <= boundary_nxt;
      periodic_priority    <= prio_nxt;
      sched_r              <= sched_nxt;
      async_grant          <= (sched_nxt == UHPD_SCH_ASYNC);
      periodic_grant       <= (sched_nxt == UHPD_SCH_PERIODIC);
      ls_start_ok          <= ls_ok_nxt;
      ports_power_ganged   <= ganged_nxt;
      overcurrent_per_port <= oc_pp_nxt;
      overcurrent_enabled  <= oc_en_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_ps_reset;
    @(posedge clk_sys) $fell(srst) |-> periodic_threshold_value_r == UHPD_PRD_RST;
  endproperty
  a_ps_reset: assert property (p_ps_reset) else $error("threshold not cleared");

  property p_lst_reset;
    @(posedge clk_sys) $fell(srst) |-> low_speed_threshold_value_r == UHPD_LS_RST;
  endproperty
  a_lst_reset: assert property (p_lst_reset) else $error("low-speed reset wrong");

  property p_dt_zero;
    @(posedge clk_sys) disable iff (srst) $past(reg_rd) && $past(reg_addr) == UHPD_ADDR_HUBDESC
      && $past(clk_en) |-> reg_rdata[UHPD_COMPOUND_BIT] == 1'b0 && reg_rdata[23:13] == 11'h0;
  endproperty
  a_dt_zero: assert property (p_dt_zero) else $error("device type not zero");

  // A new frame drops the priority, so handing the bus to async work then is legal.
  property p_no_async_in_prio;
    @(posedge clk_sys) disable iff (srst)
      clk_en && periodic_priority && !async_grant ##1 clk_en |-> !async_grant || frame_boundary;
  endproperty
  a_no_async_in_prio: assert property (p_no_async_in_prio) else $error("async after prio");

  property p_async_finish;
    @(posedge clk_sys) disable iff (srst)
      async_grant && !async_done |=> async_grant || !$past(clk_en);
  endproperty
  a_async_finish: assert property (p_async_finish) else $error("async dropped early");

  property p_ls_gate;
    @(posedge clk_sys) disable iff (srst)
      ls_start_ok |-> frame_time_left >= FI_W'(low_speed_threshold_value_r) || $past(reg_wr);
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("low-speed start below threshold");

  property p_reload;
    @(posedge clk_sys) disable iff (srst)
      frame_boundary |-> frame_time_left == $past(frame_interval_r);
  endproperty
  a_reload: assert property (p_reload) else $error("frame not reloaded");

  property p_prio_clear;
    @(posedge clk_sys) disable iff (srst) frame_boundary |-> !periodic_priority;
  endproperty
  a_prio_clear: assert property (p_prio_clear) else $error("priority kept past frame");

  property p_oc_mode;
    @(posedge clk_sys) disable iff (srst) overcurrent_per_port |-> overcurrent_enabled;
  endproperty
  a_oc_mode: assert property (p_oc_mode) else $error("mode used without protection");

  c_prio: cover property (@(posedge clk_sys) disable iff (srst) $rose(periodic_priority));
  c_boundary: cover property (@(posedge clk_sys) disable iff (srst) frame_boundary);
  c_ls_ok: cover property (@(posedge clk_sys) disable iff (srst) ls_start_ok);
  c_periodic: cover property (@(posedge clk_sys) disable iff (srst) periodic_grant);

endmodule

// [tb/uhpd_core_tb_top.sv]
// Self-checking bench for the periodic priority, low-speed gate and hub descriptor block.
`timescale 1ns/1ps
module uhpd_core_tb_top;
  import uhpd_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                 clk_sys = 1'b0;
  logic                 srst;
  logic                 clk_en;
  logic [3:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic                 async_req;
  logic                 async_done;
  logic                 periodic_req;
  logic                 periodic_done;
  logic                 ls_req;
  logic                 async_grant;
  logic                 periodic_grant;
  logic                 ls_start_ok;
  logic                 periodic_priority;
  logic                 frame_boundary;
  logic [UHPD_FI_W-1:0] frame_time_left;
  logic                 ports_power_ganged;
  logic                 overcurrent_per_port;
  logic                 overcurrent_enabled;
  int                   fail_count = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  logic [31:0]          exp_q[$];
  logic                 rd_pend = 1'b0;
  logic                 ls_chk = 1'b0;
  logic                 ls_prev = 1'b0;
  logic [11:0]          ls_thr_m;
  logic                 ls_exp;
  logic [31:0]          v;
  logic [13:0]          t;

  always #50 clk_sys = ~clk_sys;

  uhpd_core uhpd_core_i (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .clk_en               (clk_en),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .async_req            (async_req),
    .async_done           (async_done),
    .periodic_req         (periodic_req),
    .periodic_done        (periodic_done),
    .ls_req               (ls_req),
    .async_grant          (async_grant),
    .periodic_grant       (periodic_grant),
    .ls_start_ok          (ls_start_ok),
    .periodic_priority    (periodic_priority),
    .frame_boundary       (frame_boundary),
    .frame_time_left      (frame_time_left),
    .ports_power_ganged   (ports_power_ganged),
    .overcurrent_per_port (overcurrent_per_port),
    .overcurrent_enabled  (overcurrent_enabled)
  );

  // ==========================================================================
  // Compare, verdict and bus tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    n_checks++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // The expected word is queued here; the monitor pops it when the data stand.
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask

  task automatic wait_fb;
    for (int i = 0; i < 20000; i++)
    begin
      @(posedge clk_sys);
      if (frame_boundary === 1'b1)
        return;
    end
    check({31'h0, frame_boundary}, 32'h1, "frame end");
  endtask

  task automatic reset_vals;
    rd(UHPD_ADDR_PERIODIC, 32'h0000_0000);
    rd(UHPD_ADDR_LOWSPEED, 32'h0000_0628);
    rd(UHPD_ADDR_HUBDESC, 32'h0100_0900);
    rd(UHPD_ADDR_INTERVAL, 32'h0000_2EDF);
    rd(4'hF, 32'h0000_0000);
    rd(UHPD_ADDR_STATUS, 32'h0000_0000);
    check({31'h0, overcurrent_per_port}, 32'h1, "oc per port");
    check({31'h0, ports_power_ganged}, 32'h0, "ganged");
  endtask

  // ==========================================================================
  // Monitor: read data, low-speed gate and timeout
  // ==========================================================================
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rd_pend)
      check(reg_rdata, exp_q.pop_front(), "read data");
    rd_pend <= reg_rd & clk_en & ~srst;
    if (ls_chk)
    begin
      ls_exp = ls_prev && (frame_time_left >= 14'(ls_thr_m));
      check({31'h0, ls_start_ok}, {31'h0, ls_exp}, "ls gate");
    end
    ls_prev <= ls_req;
    if (cyc > 30000)
    begin
      fail_count++;
      $display("BAD %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    srst = 1'b1; clk_en = 1'b1; reg_addr = 4'h0; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; async_req = 1'b0; async_done = 1'b0;
    periodic_req = 1'b0; periodic_done = 1'b0; ls_req = 1'b0;
    v = $urandom(32'h192B);
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    reset_vals();
    // Reserved and read-only bits must swallow an all-ones write.
    wr(UHPD_ADDR_PERIODIC, 32'hFFFF_FFFF);
    rd(UHPD_ADDR_PERIODIC, 32'h0000_FFFF);
    wr(UHPD_ADDR_LOWSPEED, 32'hFFFF_FFFF);
    rd(UHPD_ADDR_LOWSPEED, 32'h0000_0FFF);
    wr(UHPD_ADDR_HUBDESC, 32'hFFFF_FFFF);
    rd(UHPD_ADDR_HUBDESC, 32'hFF00_1B00);
    wr(4'hE, 32'hFFFF_FFFF);
    rd(4'hE, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      wr(UHPD_ADDR_PERIODIC, v);
      rd(UHPD_ADDR_PERIODIC, {16'h0, v[15:0]});
      wr(UHPD_ADDR_LOWSPEED, v);
      rd(UHPD_ADDR_LOWSPEED, {20'h0, v[11:0]});
    end
    // Every combination of the protection and switching bits.
    for (int i = 0; i < 16; i++)
    begin
      v = {8'h05, 11'h0, i[3], i[2], 1'b0, i[1], i[0], 8'h00};
      wr(UHPD_ADDR_HUBDESC, v);
      rd(UHPD_ADDR_HUBDESC, v);
      check({31'h0, overcurrent_enabled}, {31'h0, !v[12]}, "oc on");
      check({31'h0, overcurrent_per_port}, {31'h0, v[11] & !v[12]}, "oc mode");
      check({31'h0, ports_power_ganged}, {31'h0, !v[9] & !v[8]}, "gang");
    end
    // A short frame keeps the priority and low-speed scenarios quick.
    // The threshold sits at ninety percent of the frame; its top two bits must be ignored.
    wr(UHPD_ADDR_INTERVAL, 32'h0000_00C8);
    ls_thr_m = 12'h03C;
    wr(UHPD_ADDR_LOWSPEED, 32'h0000_003C);
    wr(UHPD_ADDR_PERIODIC, 32'h0000_C0B4);
    wait_fb();
    wait_fb();
    check({18'h0, frame_time_left}, 32'h0000_00C8, "reload");
    ls_req <= 1'b1;
    async_req <= 1'b1;
    periodic_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ls_chk <= 1'b1;
    check({30'h0, async_grant, periodic_grant}, 32'h2, "early grant");
    check({31'h0, periodic_priority}, 32'h0, "early prio");
    for (int i = 0; i < 400 && periodic_priority !== 1'b1; i++)
      @(posedge clk_sys);
    t = frame_time_left;
    check({31'h0, t <= 14'h00B4 && t >= 14'h00B1}, 32'h1, "prio point");
    repeat (5) @(posedge clk_sys);
    check({30'h0, async_grant, periodic_grant}, 32'h2, "finish async");
    async_done <= 1'b1;
    async_req <= 1'b0;
    @(posedge clk_sys);
    async_done <= 1'b0;
    for (int i = 0; i < 4 && periodic_grant !== 1'b1; i++)
      @(posedge clk_sys);
    check({30'h0, async_grant, periodic_grant}, 32'h1, "periodic after");
    periodic_done <= 1'b1;
    periodic_req <= 1'b0;
    @(posedge clk_sys);
    periodic_done <= 1'b0;
    wait_fb();
    repeat (2) @(posedge clk_sys);
    check({31'h0, periodic_priority}, 32'h0, "prio cleared");
    // With the clock enable low nothing may move.
    ls_chk <= 1'b0;
    clk_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t = frame_time_left;
    repeat (5) @(posedge clk_sys);
    check({18'h0, frame_time_left}, {18'h0, t}, "frozen");
    clk_en <= 1'b1;
    ls_req <= 1'b0;
    // A second reset in mid-run must restore every default.
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    reset_vals();
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
